/* File: src/pfs_flash_selfprog.v */
// Program flash self-programming sequencer: table reads and writes,
// holding registers, unlock key, timed row erase and 8-byte program.
// Assumes a core that issues table instructions one at a time and an
// external flash macro with one-cycle registered read data.
//
// Operation
// - Table read fetches one byte into latch
// - Pointer bit 0 picks low or high byte
// - Table instructions can step the pointer
// - Erase clears 64-byte row, pointer bits 21:6
// - No word erase; smallest erase 32 words
// - Firmware erase limited to a single row
// - Erase ignores latch and holding contents
// - Start only after 55h then AAh keys
// - Long write stalls core; timer ends it
// - Row erase stalls about 2 ms
// - Program operation stalls about 2 ms
// - Programming always covers 8 bytes
// - Eight holding registers loaded by table writes
// - Reset during long write sets error flag
// - Write start refused while enable clear
// - Start bits settable only, hardware clears
// - Completion sets sticky write-complete flag
// - Pointer 2:0 picks register; 21:3 block
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "pfs_regs.vh"

module pfs_flash_selfprog #(
  parameter integer P_LONG_WRITE_CYCLES = `PFS_LONG_WRITE_CYCLES
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [2:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_table_read_instr,
  input wire i_table_write_instr,
  input wire [1:0] i_tbl_mode,
  output reg o_tbl_done,
  output reg o_cpu_stall,
  input wire i_master_clear_reset,
  input wire i_watchdog_timeout,
  output reg o_flash_rd,
  output reg [20:0] o_flash_word_addr,
  input wire [15:0] i_flash_rdata,
  output reg o_flash_erase,
  output reg o_flash_prog,
  output reg o_flash_abort,
  output reg [63:0] o_flash_wdata,
  output reg o_write_complete_irq_flag,
  output reg o_write_error_flag
);

  localparam [31:0] LW_LAST = P_LONG_WRITE_CYCLES - 1;
  localparam [1:0] KEY_IDLE = 2'h0;
  localparam [1:0] KEY_FIRST = 2'h1;
  localparam [1:0] KEY_ARMED = 2'h2;

  reg [21:0] byte_pointer_r;
  reg [7:0] byte_latch_r;
  reg program_space_select_r;
  reg config_space_select_r;
  reg row_erase_select_r;
  reg write_enable_bit_r;
  reg write_start_r;
  reg read_start_r;
  reg busy_r;
  reg op_erase_r;
  reg [31:0] cnt_r;
  reg [1:0] key_st_r;
  reg rd_pend_r;
  reg hi_sel_r;
  reg [1:0] rs1_r;
  reg [1:0] rs2_r;
  reg [1:0] rs3_r;
  reg [1:0] rflt_r;

  reg [21:0] step_ptr;
  reg [21:0] tbl_addr;
  reg [31:0] rd_mux;
  reg [21:0] ptr_wr;
  wire [63:0] hold_flat;
  wire bus_req;
  wire wr_take;
  wire tbl_wr_go;
  wire rst_evt;
  wire start_ok;

  // Request seen while waitrequest is high; answered one cycle later
  assign bus_req = (i_avs_read | i_avs_write) & o_avs_waitrequest & ~busy_r;
  assign wr_take = i_avs_write & ~o_avs_waitrequest;
  assign tbl_wr_go = i_table_write_instr & ~busy_r;

  // Filtered reset events; only a reset inside a long write matters
  assign rst_evt = busy_r & (|(rs2_r & rs3_r & ~rflt_r));

  // Start needs armed keys and enable set by an earlier access
  assign start_ok = i_avs_writedata[`PFS_CTL_WRITE_START] & (key_st_r == KEY_ARMED) &
                    write_enable_bit_r & i_avs_writedata[`PFS_CTL_PROGRAM_SPACE_SELECT] &
                    ~i_avs_writedata[`PFS_CTL_CONFIG_SPACE_SELECT];

  // Pointer stepping touches only the low 21 bits
  always @* begin
    step_ptr = byte_pointer_r;
    case (i_tbl_mode)
      `PFS_TBL_POSTINC, `PFS_TBL_PREINC: begin
        step_ptr = {byte_pointer_r[21], byte_pointer_r[20:0] + 21'h000001};
      end
      `PFS_TBL_POSTDEC: begin
        step_ptr = {byte_pointer_r[21], byte_pointer_r[20:0] - 21'h000001};
      end
      default: begin
        step_ptr = byte_pointer_r;
      end
    endcase
    tbl_addr = (i_tbl_mode == `PFS_TBL_PREINC) ? step_ptr : byte_pointer_r;
  end

  // Byte-lane merge for the pointer
  always @* begin
    ptr_wr = byte_pointer_r;
    if (i_avs_byteenable[0]) begin
      ptr_wr[7:0] = i_avs_writedata[7:0];
    end
    if (i_avs_byteenable[1]) begin
      ptr_wr[15:8] = i_avs_writedata[15:8];
    end
    if (i_avs_byteenable[2]) begin
      ptr_wr[21:16] = i_avs_writedata[21:16];
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (i_avs_address)
      `PFS_IDX_BYTE_POINTER: begin
        rd_mux = {10'h000, byte_pointer_r};
      end
      `PFS_IDX_BYTE_LATCH: begin
        rd_mux = {24'h000000, byte_latch_r};
      end
      `PFS_IDX_MEMORY_CONTROL: begin
        rd_mux = {24'h000000, program_space_select_r, config_space_select_r, 1'b0,
                  row_erase_select_r, o_write_error_flag, write_enable_bit_r,
                  write_start_r, read_start_r};
      end
      `PFS_IDX_STATUS: begin
        rd_mux = {30'h00000000, busy_r, o_write_complete_irq_flag};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Eight holding registers, one per pointer low-bit value
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_hold
      reg [7:0] hold_byte_r;
      always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          hold_byte_r <= `PFS_RST_HOLDING;
        end else if (tbl_wr_go && (tbl_addr[2:0] == g)) begin
          hold_byte_r <= byte_latch_r;
        end
      end
      assign hold_flat[8*g+7:8*g] = hold_byte_r;
    end
  endgenerate

  // Three-stage catch of reset requests; second and third must agree
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rs1_r <= 2'h0;
      rs2_r <= 2'h0;
      rs3_r <= 2'h0;
      rflt_r <= 2'h0;
    end else begin
      rs1_r <= {i_watchdog_timeout, i_master_clear_reset};
      rs2_r <= rs1_r;
      rs3_r <= rs2_r;
      rflt_r <= (rflt_r & (rs2_r ^ rs3_r)) | (rs3_r & ~(rs2_r ^ rs3_r));
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h00000000;
      o_avs_waitrequest <= 1'b1;
      o_tbl_done <= 1'b0;
      o_cpu_stall <= 1'b0;
      o_flash_rd <= 1'b0;
      o_flash_word_addr <= 21'h000000;
      o_flash_erase <= 1'b0;
      o_flash_prog <= 1'b0;
      o_flash_abort <= 1'b0;
      o_flash_wdata <= 64'h0000000000000000;
      o_write_complete_irq_flag <= 1'b0;
      o_write_error_flag <= 1'b0;
      byte_pointer_r <= `PFS_RST_BYTE_POINTER;
      byte_latch_r <= `PFS_RST_BYTE_LATCH;
      program_space_select_r <= 1'b0;
      config_space_select_r <= 1'b0;
      row_erase_select_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      write_start_r <= 1'b0;
      read_start_r <= 1'b0;
      busy_r <= 1'b0;
      op_erase_r <= 1'b0;
      cnt_r <= 32'h00000000;
      key_st_r <= KEY_IDLE;
      rd_pend_r <= 1'b0;
      hi_sel_r <= 1'b0;
    end else begin
      o_tbl_done <= 1'b0;
      o_flash_rd <= 1'b0;
      o_flash_erase <= 1'b0;
      o_flash_prog <= 1'b0;
      o_flash_abort <= 1'b0;
      read_start_r <= 1'b0;
      rd_pend_r <= o_flash_rd;

      // Bus answer; held off during a long write, which stalls the core
      if (!o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= i_avs_read ? rd_mux : 32'h00000000;
      end

      // Table read: word fetch, byte picked on return
      if (i_table_read_instr && !busy_r) begin
        o_flash_rd <= 1'b1;
        o_flash_word_addr <= tbl_addr[21:1];
        hi_sel_r <= tbl_addr[0];
        byte_pointer_r <= step_ptr;
      end
      if (rd_pend_r) begin
        byte_latch_r <= hi_sel_r ? i_flash_rdata[15:8] : i_flash_rdata[7:0];
        o_tbl_done <= 1'b1;
      end

      // Table write is a short write into holding registers only
      if (tbl_wr_go) begin
        byte_pointer_r <= step_ptr;
        o_tbl_done <= 1'b1;
      end

      if (wr_take) begin
        case (i_avs_address)
          `PFS_IDX_BYTE_POINTER: begin
            byte_pointer_r <= ptr_wr;
          end
          `PFS_IDX_BYTE_LATCH: begin
            if (i_avs_byteenable[0]) begin
              byte_latch_r <= i_avs_writedata[7:0];
            end
          end
          `PFS_IDX_UNLOCK_KEY: begin
            if (i_avs_byteenable[0] && (key_st_r == KEY_IDLE) &&
                (i_avs_writedata[7:0] == `PFS_KEY_FIRST)) begin
              key_st_r <= KEY_FIRST;
            end else if (i_avs_byteenable[0] && (key_st_r == KEY_FIRST) &&
                         (i_avs_writedata[7:0] == `PFS_KEY_SECOND)) begin
              key_st_r <= KEY_ARMED;
            end else begin
              key_st_r <= KEY_IDLE;
            end
          end
          `PFS_IDX_MEMORY_CONTROL: begin
            key_st_r <= KEY_IDLE;
            if (i_avs_byteenable[0]) begin
              program_space_select_r <= i_avs_writedata[`PFS_CTL_PROGRAM_SPACE_SELECT];
              config_space_select_r <= i_avs_writedata[`PFS_CTL_CONFIG_SPACE_SELECT];
              row_erase_select_r <= i_avs_writedata[`PFS_CTL_ROW_ERASE_SELECT];
              write_enable_bit_r <= i_avs_writedata[`PFS_CTL_WRITE_ENABLE];
              o_write_error_flag <= i_avs_writedata[`PFS_CTL_WRITE_ERROR_FLAG];
              // Read start only for data memory, which this block lacks
              if (i_avs_writedata[`PFS_CTL_READ_START] &&
                  !i_avs_writedata[`PFS_CTL_PROGRAM_SPACE_SELECT]) begin
                read_start_r <= 1'b1;
              end
              if (start_ok) begin
                write_start_r <= 1'b1;
                busy_r <= 1'b1;
                o_cpu_stall <= 1'b1;
                cnt_r <= LW_LAST;
                op_erase_r <= i_avs_writedata[`PFS_CTL_ROW_ERASE_SELECT];
                if (i_avs_writedata[`PFS_CTL_ROW_ERASE_SELECT]) begin
                  // Row only; data contents play no part
                  o_flash_erase <= 1'b1;
                  o_flash_word_addr <= {byte_pointer_r[21:6], 5'h00};
                end else begin
                  o_flash_prog <= 1'b1;
                  o_flash_word_addr <= {byte_pointer_r[21:3], 2'h0};
                  o_flash_wdata <= hold_flat;
                end
              end
            end
          end
          `PFS_IDX_STATUS: begin
            if (i_avs_byteenable[0] && i_avs_writedata[`PFS_STA_WRITE_COMPLETE_IRQ]) begin
              o_write_complete_irq_flag <= 1'b0;
            end
          end
          default: begin
            key_st_r <= key_st_r;
          end
        endcase
      end

      // Timer ends the long write; a filtered reset aborts it first
      if (busy_r) begin
        if (rst_evt) begin
          busy_r <= 1'b0;
          o_cpu_stall <= 1'b0;
          write_start_r <= 1'b0;
          o_flash_abort <= 1'b1;
          o_write_error_flag <= 1'b1;
        end else if (cnt_r == 32'h00000000) begin
          busy_r <= 1'b0;
          o_cpu_stall <= 1'b0;
          write_start_r <= 1'b0;
          o_write_complete_irq_flag <= 1'b1;
          if (op_erase_r) begin
            row_erase_select_r <= 1'b0;
          end
        end else begin
          cnt_r <= cnt_r - 32'h00000001;
        end
      end
    end
  end

endmodule // pfs_flash_selfprog

/* File: src/pfs_regs.vh */
// Register map, field positions, reset values and timing counts
// for the program flash self-programming sequencer.
// Assumes a word-addressed Avalon-MM slave port and a 100 MHz clock.
`ifndef PFS_REGS_VH
`define PFS_REGS_VH

// Word indices on the register bus
`define PFS_IDX_BYTE_POINTER 3'h0
`define PFS_IDX_BYTE_LATCH 3'h1
`define PFS_IDX_MEMORY_CONTROL 3'h2
`define PFS_IDX_UNLOCK_KEY 3'h3
`define PFS_IDX_STATUS 3'h4

// Control register fields
`define PFS_CTL_PROGRAM_SPACE_SELECT 7
`define PFS_CTL_CONFIG_SPACE_SELECT 6
`define PFS_CTL_ROW_ERASE_SELECT 4
`define PFS_CTL_WRITE_ERROR_FLAG 3
`define PFS_CTL_WRITE_ENABLE 2
`define PFS_CTL_WRITE_START 1
`define PFS_CTL_READ_START 0

// Status register fields
`define PFS_STA_WRITE_COMPLETE_IRQ 0
`define PFS_STA_BUSY 1

// Reset values
`define PFS_RST_BYTE_POINTER 22'h000000
`define PFS_RST_BYTE_LATCH 8'h00
`define PFS_RST_HOLDING 8'hff

// Unlock key values
`define PFS_KEY_FIRST 8'h55
`define PFS_KEY_SECOND 8'haa

// Pointer update modes for table instructions
`define PFS_TBL_KEEP 2'h0
`define PFS_TBL_POSTINC 2'h1
`define PFS_TBL_POSTDEC 2'h2
`define PFS_TBL_PREINC 2'h3

// Timing
`define PFS_CLK_PERIOD_NS 10
`define PFS_LONG_WRITE_NS 2000000
`define PFS_LONG_WRITE_CYCLES (`PFS_LONG_WRITE_NS / `PFS_CLK_PERIOD_NS)

`endif

/* File: test/pfs_flash_selfprog_props.sv */
// Checker for the self-programming sequencer, bound to its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pfs_flash_selfprog_props #(
  parameter integer P_LONG_WRITE_CYCLES = 200000
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [2:0] i_avs_address,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire o_avs_waitrequest,
  input wire i_table_read_instr,
  input wire i_table_write_instr,
  input wire o_tbl_done,
  input wire o_cpu_stall,
  input wire o_flash_rd,
  input wire [20:0] o_flash_word_addr,
  input wire o_flash_erase,
  input wire o_flash_prog,
  input wire o_flash_abort,
  input wire o_write_complete_irq_flag,
  input wire o_write_error_flag
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  reg [31:0] stall_cnt_r;
  // Counter instead of repetition: the stall may run far beyond 8 cycles
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stall_cnt_r <= 32'h0;
    end else begin
      stall_cnt_r <= o_cpu_stall ? stall_cnt_r + 32'h1 : 32'h0;
    end
  end
  a_read_fetch: assert property (i_table_read_instr && !o_cpu_stall |=> o_flash_rd ##2 o_tbl_done)
    else $error("table read timing wrong");
  a_write_load: assert property (i_table_write_instr && !o_cpu_stall |=> o_tbl_done)
    else $error("table write not done");
  a_erase_row: assert property (o_flash_erase |-> o_flash_word_addr[4:0] == 5'h00 && o_cpu_stall)
    else $error("erase not row aligned");
  a_prog_block: assert property (o_flash_prog |-> o_flash_word_addr[1:0] == 2'h0 && o_cpu_stall)
    else $error("program not block aligned");
  a_stall_cause: assert property ($rose(o_cpu_stall) |-> o_flash_erase || o_flash_prog)
    else $error("stall without start");
  a_stall_bus: assert property (o_cpu_stall |-> o_avs_waitrequest)
    else $error("bus answered in stall");
  a_stall_max: assert property (o_cpu_stall |-> stall_cnt_r <= P_LONG_WRITE_CYCLES + 1)
    else $error("stall too long");
  a_stall_min: assert property ($fell(o_cpu_stall) && !o_write_error_flag |->
    stall_cnt_r >= P_LONG_WRITE_CYCLES)
    else $error("stall too short");
  a_end_irq: assert property ($fell(o_cpu_stall) && !o_write_error_flag |->
    ##[0:1] o_write_complete_irq_flag)
    else $error("no completion flag");
  a_abort_err: assert property (o_flash_abort |-> ##[0:1] o_write_error_flag)
    else $error("abort without error flag");
  a_irq_sticky: assert property (o_write_complete_irq_flag && !(i_avs_write && !o_avs_waitrequest
    && i_avs_address == 3'h4 && i_avs_writedata[0]) |=> o_write_complete_irq_flag)
    else $error("completion flag lost");
endmodule // pfs_flash_selfprog_props
bind pfs_flash_selfprog pfs_flash_selfprog_props #(.P_LONG_WRITE_CYCLES(P_LONG_WRITE_CYCLES)) u_props (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_table_read_instr(i_table_read_instr), .i_table_write_instr(i_table_write_instr),
  .o_tbl_done(o_tbl_done), .o_cpu_stall(o_cpu_stall), .o_flash_rd(o_flash_rd),
  .o_flash_word_addr(o_flash_word_addr), .o_flash_erase(o_flash_erase), .o_flash_prog(o_flash_prog),
  .o_flash_abort(o_flash_abort), .o_write_complete_irq_flag(o_write_complete_irq_flag),
  .o_write_error_flag(o_write_error_flag));

/* File: test/pfs_flash_model.sv */
// Flash array stand-in: answers a word read one cycle after the strobe.
// Assumes the sequencer's registered read strobe and word address.
`timescale 1ns/1ps
module pfs_flash_model (
  input wire i_sys_clk,
  input wire i_flash_rd,
  input wire [20:0] i_word_addr,
  input wire i_flash_prog,
  input wire [63:0] i_wdata,
  output reg [15:0] o_rdata
);
  reg [18:0] blk_addr_r;
  reg [63:0] blk_data_r;
  initial begin
    o_rdata = 16'h0000;
    // Matches no block the tests read before programming
    blk_addr_r = 19'h7ffff;
    blk_data_r = 64'h0;
  end
  // One programmed block is kept so it can be read back
  // Off-cycle data flips so a late sample cannot pass
  always @(posedge i_sys_clk) begin
    if (i_flash_prog) begin
      blk_addr_r <= i_word_addr[20:2];
      blk_data_r <= i_wdata;
    end
    if (i_flash_rd && (i_word_addr[20:2] == blk_addr_r)) begin
      o_rdata <= blk_data_r[16*i_word_addr[1:0] +: 16];
    end else begin
      o_rdata <= i_flash_rd ? {i_word_addr[7:0] ^ 8'h3c, i_word_addr[7:0]} : ~o_rdata;
    end
  end
endmodule // pfs_flash_model

/* File: test/tb.sv */
// Testbench for the sequencer: bus master, table instructions, resets.
// Assumes the flash stand-in and a shortened long-write count.
`timescale 1ns/1ps
`include "pfs_regs.vh"
module tb;
  localparam integer LW = 20;
  reg i_sys_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg [2:0] adr = 3'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg tr = 1'b0;
  reg tw = 1'b0;
  reg [1:0] md = 2'h0;
  reg master_clear_reset = 1'b0;
  reg wdt = 1'b0;
  reg [31:0] q;
  wire [31:0] rdat;
  wire wreq, done, stall, frd, ferase, fprog, fabort, irq, err;
  wire [20:0] faddr;
  wire [15:0] fdata;
  wire [63:0] fwdata;
  integer failures = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  pfs_flash_selfprog #(.P_LONG_WRITE_CYCLES(LW)) u_pfs_flash_selfprog (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_table_read_instr(tr), .i_table_write_instr(tw), .i_tbl_mode(md),
    .o_tbl_done(done), .o_cpu_stall(stall), .i_master_clear_reset(master_clear_reset), .i_watchdog_timeout(wdt),
    .o_flash_rd(frd), .o_flash_word_addr(faddr), .i_flash_rdata(fdata), .o_flash_erase(ferase),
    .o_flash_prog(fprog), .o_flash_abort(fabort), .o_flash_wdata(fwdata),
    .o_write_complete_irq_flag(irq), .o_write_error_flag(err));
  pfs_flash_model u_pfs_flash_model (.i_sys_clk(i_sys_clk), .i_flash_rd(frd), .i_word_addr(faddr),
    .i_flash_prog(fprog), .i_wdata(fwdata), .o_rdata(fdata));
  function [7:0] bv(input [21:0] b);
    bv = b[0] ? (b[8:1] ^ 8'h3c) : b[8:1];
  endfunction
  task final_report;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      final_report;
    end
  end
  task cmp(input [63:0] got, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Request held until waitrequest is sampled low, even through a stall
  task bus(input w, input [2:0] a, input [31:0] d);
    begin
      @(posedge i_sys_clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge i_sys_clk);
      while (wreq !== 1'b0) @(posedge i_sys_clk);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task wreg(input [2:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rchk(input [2:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      cmp(q, e);
    end
  endtask
  task tbl(input is_rd, input [1:0] m);
    begin
      @(posedge i_sys_clk);
      tr <= is_rd;
      tw <= !is_rd;
      md <= m;
      @(posedge i_sys_clk);
      tr <= 1'b0;
      tw <= 1'b0;
      while (done !== 1'b1) @(posedge i_sys_clk);
    end
  endtask
  task rd_step(input [1:0] m, input [21:0] ba, input [21:0] pa);
    begin
      tbl(1'b1, m);
      rchk(`PFS_IDX_BYTE_LATCH, {24'h0, bv(ba)});
      rchk(`PFS_IDX_BYTE_POINTER, {10'h0, pa});
    end
  endtask
  task launch(input [7:0] c);
    integer n;
    begin
      wreg(`PFS_IDX_MEMORY_CONTROL, {24'h0, c});
      wreg(`PFS_IDX_UNLOCK_KEY, 32'h55);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'haa);
      wreg(`PFS_IDX_MEMORY_CONTROL, {24'h0, c | 8'h02});
      n = 0;
      while (fprog !== 1'b1 && ferase !== 1'b1 && n < 4) begin
        @(posedge i_sys_clk);
        n = n + 1;
      end
    end
  endtask
  task finish_lw;
    begin
      rchk(`PFS_IDX_STATUS, 32'h1);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      wreg(`PFS_IDX_STATUS, 32'h1);
      rchk(`PFS_IDX_STATUS, 32'h0);
    end
  endtask
  task t_reset;
    begin
      rchk(`PFS_IDX_STATUS, 32'h0);
      rchk(`PFS_IDX_BYTE_LATCH, 32'h0);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h0);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h1);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h0);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'h55);
      rchk(`PFS_IDX_UNLOCK_KEY, 32'h0);
      wreg(3'h5, 32'hff);
      rchk(3'h5, 32'h0);
      $display("reset test done");
    end
  endtask
  task t_read;
    begin
      wreg(`PFS_IDX_BYTE_POINTER, 32'h103);
      rd_step(`PFS_TBL_POSTINC, 22'h103, 22'h104);
      rd_step(`PFS_TBL_PREINC, 22'h105, 22'h105);
      rd_step(`PFS_TBL_POSTDEC, 22'h105, 22'h104);
      rd_step(`PFS_TBL_KEEP, 22'h104, 22'h104);
      $display("table read test done");
    end
  endtask
  task t_prog;
    integer k;
    begin
      wreg(`PFS_IDX_BYTE_POINTER, 32'h3c8);
      for (k = 0; k < 8; k = k + 1) begin
        wreg(`PFS_IDX_BYTE_LATCH, 32'ha0 + k);
        tbl(1'b0, `PFS_TBL_POSTINC);
      end
      launch(8'h84);
      cmp(fprog, 1'b1);
      cmp(stall, 1'b1);
      cmp(faddr, 21'h1e8);
      cmp(fwdata, 64'ha7a6a5a4a3a2a1a0);
      finish_lw;
      tbl(1'b1, `PFS_TBL_POSTINC);
      rchk(`PFS_IDX_BYTE_LATCH, 32'ha0);
      $display("program test done");
    end
  endtask
  task t_erase;
    begin
      wreg(`PFS_IDX_BYTE_POINTER, 32'h3ff);
      launch(8'h94);
      cmp(ferase, 1'b1);
      cmp(faddr, 21'h1e0);
      cmp(stall, 1'b1);
      finish_lw;
      $display("erase test done");
    end
  endtask
  task t_refuse;
    begin
      launch(8'h80);
      cmp(stall, 1'b0);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h80);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'h55);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'haa);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h86);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'haa);
      wreg(`PFS_IDX_UNLOCK_KEY, 32'h55);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h86);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      cmp(stall, 1'b0);
      $display("refusal test done");
    end
  endtask
  task t_abort(input sel);
    integer n;
    begin
      launch(8'h84);
      @(posedge i_sys_clk);
      master_clear_reset <= !sel;
      wdt <= sel;
      n = 0;
      while (fabort !== 1'b1 && n < 8) begin
        @(posedge i_sys_clk);
        n = n + 1;
      end
      cmp(fabort, 1'b1);
      cmp(stall, 1'b0);
      master_clear_reset <= 1'b0;
      wdt <= 1'b0;
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h8c);
      cmp(err, 1'b1);
      cmp(irq, 1'b0);
      wreg(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      rchk(`PFS_IDX_MEMORY_CONTROL, 32'h84);
      $display("abort test done");
    end
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    t_reset;
    t_read;
    t_erase;
    t_prog;
    t_refuse;
    t_abort(1'b0);
    t_abort(1'b1);
    final_report;
  end
endmodule // tb
